// ===== logic/rph_packet_handler.sv
// Packet handler: configuration registers, receive framer, transmit framer, receive FIFO
// Function
// - Low sync byte is a writable register resetting to 0x91.
// - High sync byte is a writable register resetting to 0xD3.
// - Fixed length mode uses the length register as exact payload length.
// - Variable length mode uses the length register as maximum allowed.
// - Preamble counter plus one on bit change, minus eight on repeat.
// - Sync accepted only while preamble counter reaches four times threshold.
// - Threshold zero accepts every sync word.
// - Autoflush set flushes receive buffer on failed CRC.
// - Append set adds signal strength byte and quality byte with CRC flag.
// - Address filter select: none, exact, plus 0x00, plus 0x00 and 0xFF.
// - Received address byte compared with device address register.
// - Whitening bit resets on, works only with legacy CRC cleared.
// - Format 00 buffered; 01 synchronous serial with data in on pin zero.
// - Format 10 transmits PN9 test data, receives as buffered.
// - Format 11 asynchronous serial, data in on pin zero, out on pin.
// - Legacy bit selects the older CRC implementation.
// - CRC enable computes CRC on transmit and checks on receive.
// - Length config 00 is fixed length from the length register.
// - Length config 01 takes length from first byte after sync.
// - Length config 10 is infinite length; 11 reserved.
`timescale 1ns/1ns
`include "rph_cfg.svh"

module rph_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } rph_fifo_state_type;
  rph_fifo_state_type f_r, f_nxt;
  logic [AW:0] used;
  logic do_push, do_pop;

  assign used = f_r.wr - f_r.rd;
  assign o_in_ready = used != (AW+1)'(DEPTH);
  assign o_out_valid = used != '0;
  assign o_out_data = f_r.mem[f_r.rd[AW-1:0]];
  assign do_push = i_in_valid && o_in_ready;
  assign do_pop = o_out_valid && i_out_ready;

  always_comb begin
    f_nxt = f_r;
    if (do_push) begin
      f_nxt.mem[f_r.wr[AW-1:0]] = i_in_data;
      f_nxt.wr = f_r.wr + (AW+1)'(1);
    end
    if (do_pop) begin
      f_nxt.rd = f_r.rd + (AW+1)'(1);
    end
    // Flush outranks both ends so a bad packet never survives
    if (i_flush) begin
      f_nxt.wr = '0;
      f_nxt.rd = '0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end
endmodule

module rph_packet_handler import rph_pkg::*; (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic [5:0] i_reg_addr,
  input wire logic i_reg_we,
  input wire logic i_reg_re,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_rx_enable,
  input wire logic i_rx_bit_stb,
  input wire logic i_rx_bit,
  input wire logic [7:0] i_rssi,
  input wire logic [6:0] i_lqi,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output logic [7:0] o_rx_data,
  output logic o_rx_pkt_done,
  output logic o_rx_overflow,
  output logic o_serial_rx_bit,
  input wire logic i_general_output_pin_zero,
  input wire logic i_tx_start,
  input wire logic i_tx_bit_stb,
  output logic o_tx_bit,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic o_tx_busy,
  output logic o_tx_underflow
);
  // ----------------------------------------
  // Coding helpers
  // ----------------------------------------
  function automatic logic [8:0] pn_next(input logic [8:0] pn);
    pn_next = {pn[0] ^ pn[5], pn[8:1]};
  endfunction

  function automatic logic [15:0] crc_bit(input logic [15:0] crc, input logic b);
    crc_bit = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? `RPH_CRC_POLY : 16'h0000);
  endfunction

  rph_state_type r, n;
  logic fifo_in_ready;
  logic [2:0] preamble_quality_threshold;
  logic [1:0] adr_sel, fmt, lencfg;
  logic wht_on, crc_en, serial, rx_on, addr_ok, byte_end, dbit;
  logic [7:0] byte_new, thr;

  assign preamble_quality_threshold = r.ctl_hi[`RPH_PQT_MSB:`RPH_PQT_LSB];
  assign adr_sel = r.ctl_hi[`RPH_ADRCHK_MSB:`RPH_ADRCHK_LSB];
  assign fmt = r.ctl_lo[`RPH_FMT_MSB:`RPH_FMT_LSB];
  assign lencfg = r.ctl_lo[`RPH_LENCFG_MSB:`RPH_LENCFG_LSB];
  assign crc_en = r.ctl_lo[`RPH_CRCEN_BIT];
  assign wht_on = r.ctl_lo[`RPH_WHITE_BIT] && !r.ctl_lo[`RPH_LEGACY_BIT];
  assign serial = fmt == `RPH_FMT_SYNC || fmt == `RPH_FMT_ASYNC;
  assign rx_on = i_rx_enable && !serial;
  assign thr = {3'h0, preamble_quality_threshold, 2'b00};
  assign dbit = i_rx_bit ^ (wht_on & r.rx_pn[0]);
  assign byte_new = {r.byte_sh[6:0], dbit};
  assign byte_end = r.bit_cnt == 3'h7;
  assign addr_ok = byte_new == r.dev_addr ||
                   (adr_sel[1] && byte_new == 8'h00) ||
                   (adr_sel == `RPH_ADR_BCFF && byte_new == 8'hFF);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic push_en;
    logic [7:0] push_data;
    logic fin;
    logic fetch;
    logic [15:0] crc_fin;
    push_en = 1'b0;
    push_data = 8'h00;
    fin = 1'b0;
    fetch = 1'b0;
    crc_fin = 16'h0000;
    n = r;
    n.flush = 1'b0;
    n.pkt_done = 1'b0;
    n.overflow = 1'b0;
    n.tx_ready = 1'b0;
    n.underflow = 1'b0;
    n.pin_s1 = i_general_output_pin_zero;
    n.pin_s2 = r.pin_s1;
    if (i_reg_we) begin
      case (i_reg_addr)
        `RPH_OFF_SYNC_HI: n.sync_hi = i_reg_wdata;
        `RPH_OFF_SYNC_LO: n.sync_lo = i_reg_wdata;
        `RPH_OFF_PKT_LEN: n.pkt_len = i_reg_wdata;
        `RPH_OFF_CTL_HI: n.ctl_hi = i_reg_wdata & `RPH_CTL_HI_MASK;
        `RPH_OFF_CTL_LO: n.ctl_lo = i_reg_wdata & `RPH_CTL_LO_MASK;
        `RPH_OFF_DEV_ADDR: n.dev_addr = i_reg_wdata;
        default: ;
      endcase
    end
    if (i_reg_re) begin
      case (i_reg_addr)
        `RPH_OFF_SYNC_HI: n.rdata = r.sync_hi;
        `RPH_OFF_SYNC_LO: n.rdata = r.sync_lo;
        `RPH_OFF_PKT_LEN: n.rdata = r.pkt_len;
        `RPH_OFF_CTL_HI: n.rdata = r.ctl_hi;
        `RPH_OFF_CTL_LO: n.rdata = r.ctl_lo;
        `RPH_OFF_DEV_ADDR: n.rdata = r.dev_addr;
        default: n.rdata = 8'h00;
      endcase
    end
    // ----------------------------------------
    // Receive framer
    // ----------------------------------------
    if (r.pend && fifo_in_ready) begin
      n.pend = 1'b0;
    end
    if (serial && i_rx_bit_stb) begin
      n.ser_out = i_rx_bit;
    end
    if (rx_on && i_rx_bit_stb) begin
      n.last_bit = i_rx_bit;
      if (i_rx_bit != r.last_bit) begin
        n.pq = (r.pq == 8'hFF) ? r.pq : r.pq + 8'h01;
      end else begin
        n.pq = (r.pq < `RPH_PQ_STEP_DOWN) ? 8'h00 : r.pq - `RPH_PQ_STEP_DOWN;
      end
    end
    if (!rx_on) begin
      n.rx_st = RPH_RX_HUNT;
    end else if (r.rx_st == RPH_RX_STAT) begin
      if (!r.pend) begin
        push_en = 1'b1;
        push_data = r.stat_ph ? {r.crc_ok, i_lqi} : i_rssi;
        n.stat_ph = 1'b1;
        if (r.stat_ph) begin
          n.rx_st = RPH_RX_HUNT;
          n.pkt_done = 1'b1;
        end
      end
    end else if (i_rx_bit_stb) begin
      unique case (r.rx_st)
        RPH_RX_HUNT: begin
          n.sync_sh = {r.sync_sh[14:0], i_rx_bit};
          if (n.sync_sh == {r.sync_hi, r.sync_lo} && (preamble_quality_threshold == 3'h0 || r.pq >= thr)) begin
            n.sync_sh = 16'h0000;
            n.bit_cnt = 3'h0;
            n.byte_cnt = 8'h00;
            n.rx_pn = `RPH_PN9_INIT;
            n.rx_crc = r.ctl_lo[`RPH_LEGACY_BIT] ? `RPH_CRC_INIT_LEGACY : `RPH_CRC_INIT;
            n.inf = lencfg == `RPH_LEN_INF;
            n.len = r.pkt_len;
            n.rx_st = (lencfg == `RPH_LEN_VAR) ? RPH_RX_LEN : RPH_RX_BODY;
          end
        end
        RPH_RX_LEN, RPH_RX_BODY, RPH_RX_CRC: begin
          n.rx_pn = pn_next(r.rx_pn);
          n.byte_sh = byte_new;
          n.bit_cnt = r.bit_cnt + 3'h1;
          n.rx_crc = crc_bit(r.rx_crc, dbit);
          if (byte_end) begin
            if (r.rx_st == RPH_RX_LEN) begin
              // Oversize or empty packets never reach the buffer
              if (byte_new > r.pkt_len || byte_new == 8'h00) begin
                n.rx_st = RPH_RX_HUNT;
              end else begin
                n.len = byte_new;
                push_en = 1'b1;
                push_data = byte_new;
                n.rx_st = RPH_RX_BODY;
              end
            end else if (r.rx_st == RPH_RX_BODY) begin
              if (r.byte_cnt == 8'h00 && adr_sel != `RPH_ADR_NONE && !addr_ok) begin
                n.flush = 1'b1;
                n.pend = 1'b0;
                n.rx_st = RPH_RX_HUNT;
              end else begin
                push_en = 1'b1;
                push_data = byte_new;
                n.byte_cnt = r.byte_cnt + 8'h01;
                if (!r.inf && n.byte_cnt == r.len) begin
                  n.byte_cnt = 8'h00;
                  if (crc_en) begin
                    n.rx_st = RPH_RX_CRC;
                  end else begin
                    n.crc_ok = 1'b1;
                    fin = 1'b1;
                  end
                end
              end
            end else begin
              n.byte_cnt = r.byte_cnt + 8'h01;
              if (r.byte_cnt == 8'h01) begin
                // Residue is zero once the appended check has been shifted through
                n.crc_ok = n.rx_crc == 16'h0000;
                if (n.rx_crc != 16'h0000 && r.ctl_hi[`RPH_AUTOFLUSH_BIT]) begin
                  n.flush = 1'b1;
                  n.pend = 1'b0;
                  n.rx_st = RPH_RX_HUNT;
                end else begin
                  fin = 1'b1;
                end
              end
            end
          end
        end
        default: n.rx_st = RPH_RX_HUNT;
      endcase
    end
    if (fin) begin
      n.stat_ph = 1'b0;
      if (r.ctl_hi[`RPH_APPEND_BIT]) begin
        n.rx_st = RPH_RX_STAT;
      end else begin
        n.rx_st = RPH_RX_HUNT;
        n.pkt_done = 1'b1;
      end
    end
    // A second byte while one still waits is lost and reported
    if (push_en) begin
      if (n.pend) begin
        n.overflow = 1'b1;
      end else begin
        n.pend = 1'b1;
        n.pend_data = push_data;
      end
    end
    // ----------------------------------------
    // Transmit framer
    // ----------------------------------------
    if (fmt != `RPH_FMT_BUF) begin
      n.tx_st = RPH_TX_IDLE;
    end
    if (i_tx_bit_stb && fmt == `RPH_FMT_PN9) begin
      n.tx_bit = r.tx_pn[0];
      n.tx_pn = pn_next(r.tx_pn);
    end else if (i_tx_bit_stb && serial) begin
      n.tx_bit = r.pin_s2;
    end else if (fmt == `RPH_FMT_BUF && r.tx_st == RPH_TX_IDLE && i_tx_start) begin
      n.tx_sh = {r.sync_hi, r.sync_lo};
      n.tx_cnt = 5'h10;
      n.tx_bytes = 8'h00;
      n.tx_pn = `RPH_PN9_INIT;
      n.tx_crc = r.ctl_lo[`RPH_LEGACY_BIT] ? `RPH_CRC_INIT_LEGACY : `RPH_CRC_INIT;
      n.tx_st = RPH_TX_SYNC;
    end else if (fmt == `RPH_FMT_BUF && r.tx_st != RPH_TX_IDLE && i_tx_bit_stb) begin
      n.tx_bit = r.tx_sh[15] ^ (wht_on && r.tx_st != RPH_TX_SYNC && r.tx_pn[0]);
      if (r.tx_st != RPH_TX_SYNC) begin
        n.tx_pn = pn_next(r.tx_pn);
      end
      crc_fin = crc_bit(r.tx_crc, r.tx_sh[15]);
      if (r.tx_st == RPH_TX_LEN || r.tx_st == RPH_TX_BODY) begin
        n.tx_crc = crc_fin;
      end
      n.tx_sh = {r.tx_sh[14:0], 1'b0};
      n.tx_cnt = r.tx_cnt - 5'h01;
      if (r.tx_cnt == 5'h01) begin
        unique case (r.tx_st)
          RPH_TX_SYNC: begin
            if (lencfg == `RPH_LEN_VAR) begin
              n.tx_sh = {r.pkt_len, 8'h00};
              n.tx_cnt = 5'h08;
              n.tx_st = RPH_TX_LEN;
            end else begin
              fetch = 1'b1;
            end
          end
          RPH_TX_LEN: fetch = 1'b1;
          RPH_TX_BODY: begin
            if (lencfg != `RPH_LEN_INF && r.tx_bytes == r.pkt_len) begin
              if (crc_en) begin
                n.tx_sh = crc_fin;
                n.tx_cnt = 5'h10;
                n.tx_st = RPH_TX_CRC;
              end else begin
                n.tx_st = RPH_TX_IDLE;
              end
            end else begin
              fetch = 1'b1;
            end
          end
          RPH_TX_CRC: n.tx_st = RPH_TX_IDLE;
          default: n.tx_st = RPH_TX_IDLE;
        endcase
      end
    end
    if (fetch) begin
      if (i_tx_valid) begin
        n.tx_sh = {i_tx_data, 8'h00};
        n.tx_cnt = 5'h08;
        n.tx_bytes = r.tx_bytes + 8'h01;
        n.tx_ready = 1'b1;
        n.tx_st = RPH_TX_BODY;
      end else begin
        // Infinite mode ends cleanly when the source runs dry
        n.underflow = lencfg != `RPH_LEN_INF;
        n.tx_st = RPH_TX_IDLE;
      end
    end
    n.tx_busy = n.tx_st != RPH_TX_IDLE;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      r <= '0;
      r.sync_hi <= `RPH_SYNC_HI_RST;
      r.sync_lo <= `RPH_SYNC_LO_RST;
      r.pkt_len <= `RPH_PKT_LEN_RST;
      r.ctl_hi <= `RPH_CTL_HI_RST;
      r.ctl_lo <= `RPH_CTL_LO_RST;
      r.dev_addr <= `RPH_DEV_ADDR_RST;
      r.rx_pn <= `RPH_PN9_INIT;
      r.tx_pn <= `RPH_PN9_INIT;
    end else begin
      r <= n;
    end
  end

  rph_fifo #(.WIDTH(8), .DEPTH(8)) u_rx_fifo (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_flush(r.flush),
    .i_in_valid(r.pend),
    .o_in_ready(fifo_in_ready),
    .i_in_data(r.pend_data),
    .o_out_valid(o_rx_valid),
    .i_out_ready(i_rx_ready),
    .o_out_data(o_rx_data)
  );

  assign o_reg_rdata = r.rdata;
  assign o_rx_pkt_done = r.pkt_done;
  assign o_rx_overflow = r.overflow;
  assign o_serial_rx_bit = r.ser_out;
  assign o_tx_bit = r.tx_bit;
  assign o_tx_ready = r.tx_ready;
  assign o_tx_busy = r.tx_busy;
  assign o_tx_underflow = r.underflow;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  sequence crc_fail_s;
    rx_on && i_rx_bit_stb && r.rx_st == RPH_RX_CRC && byte_end && r.byte_cnt == 8'h01 &&
      crc_bit(r.rx_crc, dbit) != 16'h0000 && r.ctl_hi[`RPH_AUTOFLUSH_BIT];
  endsequence
  sequence flushed_s;
    r.flush && r.rx_st == RPH_RX_HUNT ##1 !r.pend ##1 !o_rx_valid;
  endsequence

  sync_reset_a: assert property (!$past(i_reset_n) |-> r.sync_lo == 8'h91 && r.sync_hi == 8'hD3)
    else $error("sync bytes wrong after reset");
  fixed_len_a: assert property ((r.rx_st == RPH_RX_HUNT && n.rx_st == RPH_RX_BODY && lencfg == `RPH_LEN_FIXED)
    |=> r.len == $past(r.pkt_len))
    else $error("fixed length not taken from length register");
  pq_down_a: assert property ((rx_on && i_rx_bit_stb && i_rx_bit == r.last_bit && r.pq >= 8'h08)
    |=> r.pq == $past(r.pq) - 8'h08)
    else $error("preamble counter did not drop by eight");
  pq_up_a: assert property ((rx_on && i_rx_bit_stb && i_rx_bit != r.last_bit && r.pq != 8'hFF)
    |=> r.pq == $past(r.pq) + 8'h01)
    else $error("preamble counter did not rise by one");
  sync_gate_a: assert property ((r.rx_st != RPH_RX_HUNT && $past(r.rx_st) == RPH_RX_HUNT)
    |-> $past(preamble_quality_threshold) == 3'h0 || $past(r.pq) >= $past(thr))
    else $error("sync accepted below preamble threshold");
  pqt_zero_a: assert property ((rx_on && i_rx_bit_stb && r.rx_st == RPH_RX_HUNT && preamble_quality_threshold == 3'h0 &&
    {r.sync_sh[14:0], i_rx_bit} == {r.sync_hi, r.sync_lo}) |=> r.rx_st != RPH_RX_HUNT)
    else $error("sync word refused with threshold zero");
  flush_crc_a: assert property (crc_fail_s |=> flushed_s)
    else $error("bad packet not flushed");
  status_rssi_a: assert property ((rx_on && r.rx_st == RPH_RX_STAT && !r.stat_ph && !r.pend)
    |=> r.pend && r.pend_data == $past(i_rssi) ##1 r.stat_ph)
    else $error("signal strength byte not appended");
  addr_drop_a: assert property ((rx_on && i_rx_bit_stb && r.rx_st == RPH_RX_BODY && byte_end &&
    r.byte_cnt == 8'h00 && adr_sel != `RPH_ADR_NONE && !addr_ok) |=> flushed_s)
    else $error("foreign address not dropped");
  len_limit_a: assert property ((rx_on && i_rx_bit_stb && r.rx_st == RPH_RX_LEN && byte_end &&
    byte_new > r.pkt_len) |=> r.rx_st == RPH_RX_HUNT && !(r.pend && !$past(r.pend)))
    else $error("oversize packet not discarded");
  pn9_tx_a: assert property ((fmt == `RPH_FMT_PN9 && i_tx_bit_stb) |=> o_tx_bit == $past(r.tx_pn[0]))
    else $error("test mode bit not from PN9");
  serial_tx_a: assert property ((serial && i_tx_bit_stb) |=> o_tx_bit == $past(r.pin_s2))
    else $error("serial transmit bit not from pin zero");
endmodule

// ===== logic/rph_cfg.svh
// Offsets, field positions, reset values and coding constants of the packet handler
`ifndef RPH_CFG_SVH
`define RPH_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RPH_OFF_SYNC_HI 6'h04
`define RPH_OFF_SYNC_LO 6'h05
`define RPH_OFF_PKT_LEN 6'h06
`define RPH_OFF_CTL_HI 6'h07
`define RPH_OFF_CTL_LO 6'h08
`define RPH_OFF_DEV_ADDR 6'h09
// ----------------------------------------
// Reset values and write masks
// ----------------------------------------
`define RPH_SYNC_HI_RST 8'hD3
`define RPH_SYNC_LO_RST 8'h91
`define RPH_PKT_LEN_RST 8'hFF
`define RPH_CTL_HI_RST 8'h04
`define RPH_CTL_LO_RST 8'h45
`define RPH_DEV_ADDR_RST 8'h00
`define RPH_CTL_HI_MASK 8'hEF
`define RPH_CTL_LO_MASK 8'h7F
// ----------------------------------------
// Field positions
// ----------------------------------------
`define RPH_PQT_MSB 7
`define RPH_PQT_LSB 5
`define RPH_AUTOFLUSH_BIT 3
`define RPH_APPEND_BIT 2
`define RPH_ADRCHK_MSB 1
`define RPH_ADRCHK_LSB 0
`define RPH_WHITE_BIT 6
`define RPH_FMT_MSB 5
`define RPH_FMT_LSB 4
`define RPH_LEGACY_BIT 3
`define RPH_CRCEN_BIT 2
`define RPH_LENCFG_MSB 1
`define RPH_LENCFG_LSB 0
// ----------------------------------------
// Encodings and coding constants
// ----------------------------------------
`define RPH_FMT_BUF 2'b00
`define RPH_FMT_SYNC 2'b01
`define RPH_FMT_PN9 2'b10
`define RPH_FMT_ASYNC 2'b11
`define RPH_LEN_FIXED 2'b00
`define RPH_LEN_VAR 2'b01
`define RPH_LEN_INF 2'b10
`define RPH_ADR_NONE 2'b00
`define RPH_ADR_BC00 2'b10
`define RPH_ADR_BCFF 2'b11
`define RPH_PQ_STEP_DOWN 8'h08
`define RPH_PN9_INIT 9'h1FF
`define RPH_CRC_POLY 16'h8005
`define RPH_CRC_INIT 16'hFFFF
`define RPH_CRC_INIT_LEGACY 16'h0000
`endif

// ===== logic/rph_pkg.sv
// Types shared by the packet handler
package rph_pkg;
  // ----------------------------------------
  // State encodings
  // ----------------------------------------
  typedef enum logic [2:0] {
    RPH_RX_HUNT = 3'h0,
    RPH_RX_LEN = 3'h1,
    RPH_RX_BODY = 3'h3,
    RPH_RX_CRC = 3'h2,
    RPH_RX_STAT = 3'h6
  } rph_rx_state_type;
  typedef enum logic [2:0] {
    RPH_TX_IDLE = 3'h0,
    RPH_TX_SYNC = 3'h1,
    RPH_TX_LEN = 3'h3,
    RPH_TX_BODY = 3'h2,
    RPH_TX_CRC = 3'h6
  } rph_tx_state_type;
  // ----------------------------------------
  // Handler state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] sync_hi, sync_lo, pkt_len, ctl_hi, ctl_lo, dev_addr, rdata;
    logic pin_s1, pin_s2;
    rph_rx_state_type rx_st;
    logic [7:0] pq;
    logic last_bit;
    logic [15:0] sync_sh;
    logic [2:0] bit_cnt;
    logic [7:0] byte_sh, byte_cnt, len;
    logic inf;
    logic [15:0] rx_crc;
    logic [8:0] rx_pn;
    logic pend;
    logic [7:0] pend_data;
    logic stat_ph, crc_ok, flush, pkt_done, overflow, ser_out;
    rph_tx_state_type tx_st;
    logic [15:0] tx_sh;
    logic [4:0] tx_cnt;
    logic [7:0] tx_bytes;
    logic [15:0] tx_crc;
    logic [8:0] tx_pn;
    logic tx_bit, tx_ready, tx_busy, underflow;
  } rph_state_type;
endpackage

// ===== sim/rph_remote_radio.sv
// Remote transceiver model driving the receive bit stream
`timescale 1ns/1ns
module rph_remote_radio (
  input wire logic i_clk_sys,
  output logic o_bit_stb,
  output logic o_bit
);
  initial begin
    o_bit_stb = 1'b0;
    o_bit = 1'b0;
  end
  // Bits MSB first, one strobe every fourth cycle; one byte per call
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(negedge i_clk_sys);
      o_bit = b[i];
      o_bit_stb = 1'b1;
      @(negedge i_clk_sys);
      o_bit_stb = 1'b0;
      // Stale bit inverted so a late sample shows up
      o_bit = ~b[i];
      repeat (2) @(negedge i_clk_sys);
    end
  endtask
endmodule

// ===== sim/tb_rph_packet_handler.sv
// Self-checking bench for the packet handler
`timescale 1ns/1ns
`include "rph_cfg.svh"
module tb_rph_packet_handler;
  logic clk, rst_n, we, re, rx_en, stb, rbit, rx_valid, rx_ready, gpin, tx_start, tx_stb, tx_valid;
  logic done, ovf, serbit, txbit, txrdy, busy, unf;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, rx_data, rssi, tx_data;
  logic [6:0] lqi;
  int fails = 0;
  int checks_done = 0;
  rph_packet_handler u_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_reg_addr(addr), .i_reg_we(we),
    .i_reg_re(re), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_rx_enable(rx_en), .i_rx_bit_stb(stb),
    .i_rx_bit(rbit), .i_rssi(rssi), .i_lqi(lqi), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready),
    .o_rx_data(rx_data), .o_rx_pkt_done(done), .o_rx_overflow(ovf), .o_serial_rx_bit(serbit),
    .i_general_output_pin_zero(gpin), .i_tx_start(tx_start), .i_tx_bit_stb(tx_stb), .o_tx_bit(txbit),
    .i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(txrdy), .o_tx_busy(busy), .o_tx_underflow(unf));
  rph_remote_radio u_radio (.i_clk_sys(clk), .o_bit_stb(stb), .o_bit(rbit));
  int done_cnt = 0;
  int ovf_cnt = 0;
  // Pulses last one full cycle, so a falling edge sees each exactly once
  always @(negedge clk) begin
    if (done === 1'b1) begin
      done_cnt++;
    end
    if (ovf === 1'b1) begin
      ovf_cnt++;
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    re = 1'b1;
    @(negedge clk);
    re = 1'b0;
    chk8("reg", e, rdata);
  endtask
  task automatic pop_chk(input logic [7:0] e);
    int n;
    n = 0;
    while (rx_valid !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk8("rx_data", e, rx_data);
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
  endtask
  task automatic send_pkt(input logic [7:0] a, input logic [7:0] b);
    u_radio.send_byte(8'hD3);
    u_radio.send_byte(8'h91);
    u_radio.send_byte(a);
    u_radio.send_byte(b);
    repeat (12) @(negedge clk);
  endtask
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c;
    for (int i = 7; i >= 0; i--) begin
      x = {x[14:0], 1'b0} ^ ((x[15] ^ d[i]) ? `RPH_CRC_POLY : 16'h0000);
    end
    return x;
  endfunction
  task automatic tx_pulse;
    @(negedge clk);
    tx_stb = 1'b1;
    @(negedge clk);
    tx_stb = 1'b0;
  endtask
  task automatic finish_test;
    if (fails == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd_chk(`RPH_OFF_SYNC_HI, 8'hD3);
    rd_chk(`RPH_OFF_SYNC_LO, 8'h91);
    rd_chk(`RPH_OFF_PKT_LEN, 8'hFF);
    rd_chk(`RPH_OFF_CTL_HI, 8'h04);
    rd_chk(`RPH_OFF_CTL_LO, 8'h45);
    rd_chk(`RPH_OFF_DEV_ADDR, 8'h00);
    wr(`RPH_OFF_SYNC_LO, 8'h5A);
    rd_chk(`RPH_OFF_SYNC_LO, 8'h5A);
    wr(`RPH_OFF_CTL_HI, 8'hFF);
    rd_chk(`RPH_OFF_CTL_HI, 8'hEF);
    rd_chk(6'h3F, 8'h00);
  endtask
  task automatic t_fixed;
    wr(`RPH_OFF_SYNC_LO, 8'h91);
    wr(`RPH_OFF_CTL_HI, 8'h00);
    wr(`RPH_OFF_CTL_LO, 8'h00);
    wr(`RPH_OFF_PKT_LEN, 8'h02);
    send_pkt(8'hA5, 8'h3C);
    pop_chk(8'hA5);
    pop_chk(8'h3C);
    chk8("rx_valid", 8'h00, {7'h00, rx_valid});
  endtask
  task automatic t_var;
    wr(`RPH_OFF_CTL_LO, 8'h01);
    send_pkt(8'h03, 8'h11);
    chk8("rx_valid", 8'h00, {7'h00, rx_valid});
    send_pkt(8'h01, 8'h7E);
    pop_chk(8'h01);
    pop_chk(8'h7E);
    wr(`RPH_OFF_DEV_ADDR, 8'h42);
    wr(`RPH_OFF_CTL_HI, 8'h01);
    send_pkt(8'h01, 8'h43);
    chk8("rx_valid", 8'h00, {7'h00, rx_valid});
    send_pkt(8'h01, 8'h42);
    pop_chk(8'h01);
    pop_chk(8'h42);
  endtask
  task automatic t_crc;
    logic [15:0] c;
    c = crc16(crc16(`RPH_CRC_INIT, 8'h01), 8'h5A);
    wr(`RPH_OFF_CTL_HI, 8'h0C);
    wr(`RPH_OFF_CTL_LO, 8'h05);
    send_pkt(8'h01, 8'h5A);
    u_radio.send_byte(c[15:8]);
    u_radio.send_byte(c[7:0]);
    repeat (12) @(negedge clk);
    pop_chk(8'h01);
    pop_chk(8'h5A);
    pop_chk(rssi);
    pop_chk({1'b1, lqi});
    chk8("pkt_done", 8'h04, done_cnt[7:0]);
    send_pkt(8'h01, 8'h5A);
    u_radio.send_byte(~c[15:8]);
    u_radio.send_byte(~c[7:0]);
    repeat (12) @(negedge clk);
    chk8("rx_valid", 8'h00, {7'h00, rx_valid});
    chk8("pkt_done", 8'h04, done_cnt[7:0]);
  endtask
  // Ten bytes into eight slots plus the waiting byte: exactly one lost
  task automatic t_over;
    wr(`RPH_OFF_CTL_HI, 8'h00);
    wr(`RPH_OFF_CTL_LO, 8'h00);
    wr(`RPH_OFF_PKT_LEN, 8'h0A);
    send_pkt(8'h20, 8'h21);
    for (int i = 2; i < 10; i++) begin
      u_radio.send_byte(8'h20 + 8'(i));
    end
    repeat (12) @(negedge clk);
    chk8("overflow", 8'h01, ovf_cnt[7:0]);
    chk8("pkt_done", 8'h05, done_cnt[7:0]);
    for (int i = 0; i < 9; i++) begin
      pop_chk(8'h20 + 8'(i));
    end
    chk8("rx_valid", 8'h00, {7'h00, rx_valid});
  endtask
  task automatic t_tx;
    logic [8:0] pn;
    logic [23:0] frame;
    pn = `RPH_PN9_INIT;
    frame = 24'hD391A7;
    wr(`RPH_OFF_CTL_LO, 8'h20);
    for (int i = 0; i < 12; i++) begin
      tx_pulse();
      chk8("tx_bit", {7'h00, pn[0]}, {7'h00, txbit});
      pn = {pn[0] ^ pn[5], pn[8:1]};
    end
    gpin = 1'b1;
    wr(`RPH_OFF_CTL_LO, 8'h10);
    tx_pulse();
    chk8("tx_bit", 8'h01, {7'h00, txbit});
    gpin = 1'b0;
    wr(`RPH_OFF_CTL_LO, 8'h30);
    tx_pulse();
    chk8("tx_bit", 8'h00, {7'h00, txbit});
    u_radio.send_byte(8'h01);
    chk8("serial_rx", 8'h01, {7'h00, serbit});
    chk8("rx_valid", 8'h00, {7'h00, rx_valid});
    wr(`RPH_OFF_CTL_LO, 8'h00);
    wr(`RPH_OFF_PKT_LEN, 8'h01);
    tx_data = 8'hA7;
    tx_valid = 1'b1;
    @(negedge clk);
    tx_start = 1'b1;
    @(negedge clk);
    tx_start = 1'b0;
    chk8("tx_busy", 8'h01, {7'h00, busy});
    for (int i = 23; i >= 0; i--) begin
      tx_pulse();
      chk8("tx_bit", {7'h00, frame[i]}, {7'h00, txbit});
      if (i == 8) begin
        chk8("tx_ready", 8'h01, {7'h00, txrdy});
      end
    end
    tx_valid = 1'b0;
    chk8("tx_busy", 8'h00, {7'h00, busy});
    @(negedge clk);
    tx_start = 1'b1;
    @(negedge clk);
    tx_start = 1'b0;
    repeat (16) tx_pulse();
    chk8("tx_underflow", 8'h01, {7'h00, unf});
    chk8("tx_busy", 8'h00, {7'h00, busy});
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Roughly ten times the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end
  initial begin
    rst_n = 1'b0;
    {we, re, rx_ready, gpin, tx_start, tx_stb, tx_valid} = 7'h00;
    addr = 6'h00;
    wdata = 8'h00;
    tx_data = 8'h00;
    rssi = 8'h80;
    lqi = 7'h15;
    rx_en = 1'b1;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_regs();
    t_fixed();
    t_var();
    t_crc();
    t_over();
    t_tx();
    finish_test();
  end
endmodule
